// >>> src/fsp_pkg.sv
// constants and types for the flag and sync pin configuration block
package fsp_pkg;
  localparam int unsigned ADDR_W         = 16;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned EV_W           = 3;

  localparam logic [15:0] SYNC_DLY_ADDR  = 16'hFE0D;
  localparam logic [15:0] SYNC_SEL_ADDR  = 16'hFE0E;
  localparam logic [15:0] PIN_FUNC_ADDR  = 16'hFE0F;
  localparam logic [15:0] IRQ_STAT_ADDR  = 16'hFE30;
  localparam logic [15:0] IRQ_MASK_ADDR  = 16'hFE31;

  localparam logic [7:0]  SYNC_DLY_RST   = 8'h00;
  localparam logic [7:0]  SYNC_SEL_RST   = 8'h00;
  localparam logic [7:0]  PIN_FUNC_RST   = 8'h00;
  localparam logic [2:0]  IRQ_MASK_RST   = 3'h0;

  // pin function register fields
  localparam int unsigned IN_FUNC_BIT    = 0;
  localparam int unsigned IN_DEB_BIT     = 1;
  localparam int unsigned IN_POL_BIT     = 2;
  localparam int unsigned OUT_FUNC_BIT   = 3;
  localparam int unsigned OUT_SEL_BIT    = 4;
  localparam int unsigned OUT_POL_BIT    = 5;
  localparam int unsigned B_ILV_BIT      = 6;
  // sync select register field
  localparam int unsigned OUT_REF_BIT    = 3;

  // interrupt status and mask fields
  localparam int unsigned EV_FLAG_I_BIT  = 0;
  localparam int unsigned EV_FLAG_O_BIT  = 1;
  localparam int unsigned EV_SYNC_BIT    = 2;

  // timing
  localparam int unsigned CLK_PERIOD_PS  = 8000;
  localparam int unsigned SYNC_STEP_NS   = 80;
  localparam int unsigned SYNC_STEP_CYC  =
    (SYNC_STEP_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned DEBOUNCE_US    = 100;
  localparam int unsigned DEBOUNCE_CYC   =
    (DEBOUNCE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SYNC_CNT_W     = 12;

  typedef enum logic [1:0] {
    SY_IDLE = 2'b00,
    SY_WAIT = 2'b01,
    SY_FIRE = 2'b11
  } fsp_sync_state_type;
endpackage : fsp_pkg

// >>> src/fsp_debounce.sv
// stable-level filter for the flag input, with a bypass
`timescale 1ns/1ps
module fsp_debounce #(
  parameter int unsigned STABLE_CYC = 12500
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic bypass_i,
  input  wire logic raw_i,
  output logic      filt_o
);
  localparam int unsigned CNT_W = $clog2(STABLE_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STABLE_CYC - 1);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             filt_q;
  logic             filt_d;

  wire differ = raw_i != filt_q;
  wire done   = differ && cnt_q == CNT_LAST;

  // any glitch back to the held level restarts the count
  assign cnt_d  = (bypass_i || !differ || done) ? '0 : cnt_q + 1'b1;
  assign filt_d = (bypass_i || done) ? raw_i : filt_q;
  assign filt_o = filt_q;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      filt_q <= 1'b0;
    end else if (ce_i) begin
      cnt_q  <= cnt_d;
      filt_q <= filt_d;
    end
  end

  property p_deb_hold;
    @(posedge clk_sys_i) disable iff (rst_i)
    !rst_i && ce_i && !bypass_i && filt_q != raw_i && cnt_q != CNT_LAST
      |=> $stable(filt_q);
  endproperty
  a_deb_hold: assert property (p_deb_hold)
    else $error("filtered flag changed before the level was stable");
endmodule : fsp_debounce

// >>> src/fsp_flag_sync_pin_config.sv
// flag and synchronization dual-purpose pin configuration block
//
// What this block does
// - interleave bit shifts channel B ADC clock by 180 degrees.
// - output polarity 0 drives pin high on flag; 1 drives it low.
// - flag source 0 picks channel A light-load flag, 1 picks channel B.
// - output pin function 0 carries sync output, 1 carries flag output.
// - input polarity 0 means high pin asserts flag; 1 means low pin.
// - debounce bit 0 gives no filter, 1 gives a 100 us filter.
// - input pin function 0 is sync input, 1 is flag input.
// - sync output copies channel C clock when select 0, channel A when 1.
// - sync reference follows input rising edge, delayed in 80 ns steps.
`timescale 1ns/1ps
module fsp_flag_sync_pin_config #(
  parameter int unsigned DEBOUNCE_CYCLES = fsp_pkg::DEBOUNCE_CYC
) (
  input  wire logic                        clk_sys_i,
  input  wire logic                        rst_i,
  input  wire logic                        ce_i,
  input  wire logic [fsp_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [fsp_pkg::DATA_W-1:0]  wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [fsp_pkg::DATA_W-1:0]  rdata_o,
  input  wire logic                        dual_in_pin_i,
  output logic                             dual_out_pin_o,
  input  wire logic                        light_load_flag_chan_a_i,
  input  wire logic                        light_load_flag_chan_b_i,
  input  wire logic                        chan_a_clk_i,
  input  wire logic                        chan_c_clk_i,
  input  wire logic                        chan_b_clk_i,
  output logic                             chan_b_adc_clk_o,
  output logic                             flag_input_signal_o,
  output logic                             sync_ref_o,
  output logic                             irq_o
);
  import fsp_pkg::*;

  // register file
  logic [DATA_W-1:0] pin_func_q;
  logic [DATA_W-1:0] sync_dly_q;
  logic [DATA_W-1:0] sync_sel_q;
  logic [EV_W-1:0]   irq_stat_q;
  logic [EV_W-1:0]   irq_stat_d;
  logic [EV_W-1:0]   irq_mask_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  wire hit_func = addr_i == PIN_FUNC_ADDR;
  wire hit_dly  = addr_i == SYNC_DLY_ADDR;
  wire hit_sel  = addr_i == SYNC_SEL_ADDR;
  wire hit_stat = addr_i == IRQ_STAT_ADDR;
  wire hit_mask = addr_i == IRQ_MASK_ADDR;

  wire wr_func  = wr_i && hit_func;
  wire wr_dly   = wr_i && hit_dly;
  wire wr_sel   = wr_i && hit_sel;
  wire wr_mask  = wr_i && hit_mask;
  wire rd_stat  = rd_i && hit_stat;

  // field views
  wire in_func  = pin_func_q[IN_FUNC_BIT];
  wire in_deb   = pin_func_q[IN_DEB_BIT];
  wire in_pol   = pin_func_q[IN_POL_BIT];
  wire out_func = pin_func_q[OUT_FUNC_BIT];
  wire out_sel  = pin_func_q[OUT_SEL_BIT];
  wire out_pol  = pin_func_q[OUT_POL_BIT];
  wire b_ilv    = pin_func_q[B_ILV_BIT];
  wire out_ref  = sync_sel_q[OUT_REF_BIT];

  // unmapped addresses read as zero
  wire [DATA_W-1:0] rd_mux =
    hit_func ? pin_func_q :
    hit_dly  ? sync_dly_q :
    hit_sel  ? sync_sel_q :
    hit_stat ? {{(DATA_W-EV_W){1'b0}}, irq_stat_q} :
    hit_mask ? {{(DATA_W-EV_W){1'b0}}, irq_mask_q} :
    '0;

  // read data stand one cycle after rd_i, for as many cycles as rd_i is high
  assign rdata_d = rd_i ? rd_mux : '0;
  assign rdata_o = rdata_q;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pin_func_q <= PIN_FUNC_RST;
      sync_dly_q <= SYNC_DLY_RST;
      sync_sel_q <= SYNC_SEL_RST;
      irq_mask_q <= IRQ_MASK_RST;
      irq_stat_q <= '0;
      rdata_q    <= '0;
    end else if (ce_i) begin
      if (wr_func) pin_func_q <= wdata_i;
      if (wr_dly)  sync_dly_q <= wdata_i;
      if (wr_sel)  sync_sel_q <= wdata_i;
      if (wr_mask) irq_mask_q <= wdata_i[EV_W-1:0];
      irq_stat_q <= irq_stat_d;
      rdata_q    <= rdata_d;
    end
  end

  // output pin path (flag or sync) and channel B ADC clock
  logic out_pin_q;
  logic flag_out_prev_q;
  logic adc_clk_q;

  wire flag_sel = out_sel ? light_load_flag_chan_b_i
                          : light_load_flag_chan_a_i;
  // polarity only matters in flag mode
  wire flag_lvl = flag_sel ^ out_pol;
  wire sync_src = out_ref ? chan_a_clk_i : chan_c_clk_i;
  wire out_d    = out_func ? flag_lvl : sync_src;
  wire flag_out_act = out_func && flag_sel;

  // a 50 percent clock inverted is the half-period shifted copy
  wire adc_clk_d = chan_b_clk_i ^ b_ilv;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      out_pin_q       <= 1'b0;
      flag_out_prev_q <= 1'b0;
      adc_clk_q       <= 1'b0;
    end else if (ce_i) begin
      out_pin_q       <= out_d;
      flag_out_prev_q <= flag_out_act;
      adc_clk_q       <= adc_clk_d;
    end
  end

  assign dual_out_pin_o   = out_pin_q;
  assign chan_b_adc_clk_o = adc_clk_q;

  // flag input path
  logic deb_flag;
  logic flag_in_prev_q;

  wire in_asserted = dual_in_pin_i ^ in_pol;

  fsp_debounce #(
    .STABLE_CYC (DEBOUNCE_CYCLES)
  ) u_debounce (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .bypass_i  (!in_deb),
    .raw_i     (in_asserted),
    .filt_o    (deb_flag)
  );

  assign flag_input_signal_o = in_func && deb_flag;

  // sync input path
  fsp_sync_state_type      sy_state_q;
  fsp_sync_state_type      sy_state_d;
  logic [SYNC_CNT_W-1:0]   sy_cnt_q;
  logic [SYNC_CNT_W-1:0]   sy_cnt_d;
  logic                    in_pin_prev_q;

  wire sync_mode = !in_func;
  wire sync_rise = sync_mode && dual_in_pin_i && !in_pin_prev_q;
  wire dly_zero  = sync_dly_q == '0;
  wire [SYNC_CNT_W-1:0] sy_load =
    SYNC_CNT_W'(32'(sync_dly_q) * SYNC_STEP_CYC - 1);

  // edges that arrive while a delay runs are dropped
  always_comb begin
    sy_state_d = sy_state_q;
    sy_cnt_d   = sy_cnt_q;
    unique case (sy_state_q)
      SY_IDLE: begin
        if (sync_rise) begin
          sy_state_d = dly_zero ? SY_FIRE : SY_WAIT;
          sy_cnt_d   = sy_load;
        end
      end
      SY_WAIT: begin
        if (!sync_mode) begin
          sy_state_d = SY_IDLE;
        end else if (sy_cnt_q == '0) begin
          sy_state_d = SY_FIRE;
        end else begin
          sy_cnt_d = sy_cnt_q - 1'b1;
        end
      end
      SY_FIRE: begin
        sy_state_d = SY_IDLE;
      end
      default: begin
        sy_state_d = SY_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sy_state_q     <= SY_IDLE;
      sy_cnt_q       <= '0;
      // high so a pin already high out of reset gives no false edge
      in_pin_prev_q  <= 1'b1;
      flag_in_prev_q <= 1'b0;
    end else if (ce_i) begin
      sy_state_q     <= sy_state_d;
      sy_cnt_q       <= sy_cnt_d;
      in_pin_prev_q  <= dual_in_pin_i;
      flag_in_prev_q <= flag_input_signal_o;
    end
  end

  assign sync_ref_o = sy_state_q == SY_FIRE;

  // interrupts: a new event beats the clear-on-read
  logic [EV_W-1:0] ev;
  always_comb begin
    ev = '0;
    ev[EV_FLAG_I_BIT]  = flag_input_signal_o && !flag_in_prev_q;
    ev[EV_FLAG_O_BIT]  = flag_out_act && !flag_out_prev_q;
    ev[EV_SYNC_BIT]    = sy_state_q == SY_FIRE;
  end

  assign irq_stat_d = (rd_stat ? '0 : irq_stat_q) | ev;
  assign irq_o      = |(irq_stat_q & irq_mask_q);

  // checks
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  // sampled reset keeps attempts off the edge that releases reset
  wire chk_run = ce_i && !rst_i;

  property p_adc_shift;
    chk_run && b_ilv ##1 ce_i
      |-> chan_b_adc_clk_o == !$past(chan_b_clk_i);
  endproperty
  a_adc_shift: assert property (p_adc_shift)
    else $error("channel B ADC clock not inverted under interleave");

  property p_adc_plain;
    chk_run && !b_ilv
      |=> chan_b_adc_clk_o == $past(chan_b_clk_i);
  endproperty
  a_adc_plain: assert property (p_adc_plain)
    else $error("channel B ADC clock shifted without interleave");

  property p_flag_inv;
    chk_run && out_func && out_pol && out_sel
      |=> dual_out_pin_o == !$past(light_load_flag_chan_b_i);
  endproperty
  a_flag_inv: assert property (p_flag_inv)
    else $error("inverted flag output level wrong");

  property p_flag_inv_a;
    chk_run && out_func && out_pol && !out_sel
      |=> dual_out_pin_o == !$past(light_load_flag_chan_a_i);
  endproperty
  a_flag_inv_a: assert property (p_flag_inv_a)
    else $error("inverted channel A flag output level wrong");

  property p_flag_a;
    chk_run && out_func && !out_pol && !out_sel
      |=> dual_out_pin_o == $past(light_load_flag_chan_a_i);
  endproperty
  a_flag_a: assert property (p_flag_a)
    else $error("flag output does not follow channel A flag");

  property p_flag_b;
    chk_run && out_func && !out_pol && out_sel
      |=> dual_out_pin_o == $past(light_load_flag_chan_b_i);
  endproperty
  a_flag_b: assert property (p_flag_b)
    else $error("flag output does not follow channel B flag");

  property p_sync_out_a;
    chk_run && !out_func && out_ref
      |=> dual_out_pin_o == $past(chan_a_clk_i);
  endproperty
  a_sync_out_a: assert property (p_sync_out_a)
    else $error("sync output does not follow channel A clock");

  property p_sync_out_c;
    chk_run && !out_func && !out_ref
      |=> dual_out_pin_o == $past(chan_c_clk_i);
  endproperty
  a_sync_out_c: assert property (p_sync_out_c)
    else $error("sync output does not follow channel C clock");

  property p_flag_in_raw;
    chk_run && in_func && !in_deb ##1 in_func
      |-> flag_input_signal_o == ($past(dual_in_pin_i) ^ $past(in_pol));
  endproperty
  a_flag_in_raw: assert property (p_flag_in_raw)
    else $error("undebounced flag input level wrong");

  property p_sync_no_flag;
    !in_func |-> !flag_input_signal_o;
  endproperty
  a_sync_no_flag: assert property (p_sync_no_flag)
    else $error("flag input asserted while pin is in sync mode");

  property p_sync_off;
    chk_run && !sync_mode
      |=> !sync_ref_o;
  endproperty
  a_sync_off: assert property (p_sync_off)
    else $error("sync reference pulse while pin is in flag mode");

  property p_ref_nodly;
    chk_run && sy_state_q == SY_IDLE && sync_rise && dly_zero
      |=> sync_ref_o ##1 !sync_ref_o;
  endproperty
  a_ref_nodly: assert property (p_ref_nodly)
    else $error("zero-delay sync reference pulse missing");

  property p_ref_wait;
    chk_run && sy_state_q == SY_WAIT && sync_mode && sy_cnt_q == '0
      |=> sync_ref_o;
  endproperty
  a_ref_wait: assert property (p_ref_wait)
    else $error("sync reference pulse late after delay");

  // an event must survive a clear-on-read in the same edge
  property p_stat_set;
    chk_run && |ev
      |=> (irq_stat_q & $past(ev)) == $past(ev);
  endproperty
  a_stat_set: assert property (p_stat_set)
    else $error("status bit lost on the edge of its event");

  property p_stat_clear;
    chk_run && rd_stat && ev == '0
      |=> irq_stat_q == '0;
  endproperty
  a_stat_clear: assert property (p_stat_clear)
    else $error("status not cleared by its read");

  property p_rdata_idle;
    chk_run && !rd_i
      |=> rdata_o == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside the read answer");

  property p_freeze;
    !rst_i && !ce_i
      |=> $stable(pin_func_q) && $stable(dual_out_pin_o);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while the clock enable was low");

  c_sync_delayed: cover property (sy_state_q == SY_WAIT ##[1:40] sync_ref_o);
  c_flag_in_deb: cover property (in_deb && $rose(flag_input_signal_o));
  c_irq: cover property ($rose(irq_o));
  c_stat_read: cover property (rd_stat && |irq_stat_q);
endmodule : fsp_flag_sync_pin_config

// >>> test/fsp_far_end.sv
// far-side model: peer channel clocks and the level on the dual input pin
`timescale 1ns/1ps
module fsp_far_end (
  input  wire logic clk_sys_i,
  input  wire logic lvl_i,
  output logic      pin_o,
  output logic      a_clk_o,
  output logic      b_clk_o,
  output logic      c_clk_o
);
  logic [3:0] cnt_q = 4'h0;

  // clocks move just after the edge, as a real peer's would
  always_ff @(posedge clk_sys_i) begin
    cnt_q <= cnt_q + 4'h1;
  end
  // different rates so a wrong channel pick shows up
  assign a_clk_o = cnt_q[1];
  assign b_clk_o = cnt_q[0];
  assign c_clk_o = cnt_q[3];
  // peer drives the pin at all times, no pull needed
  assign pin_o   = lvl_i;
endmodule : fsp_far_end

// >>> test/fsp_flag_sync_pin_config_bench.sv
// self-checking bench for the flag and sync pin configuration block
`timescale 1ns/1ps
module fsp_flag_sync_pin_config_bench;
  import fsp_pkg::*;
  typedef struct packed {
    logic [7:0] fn;
    logic [7:0] sel;
    logic [2:0] lv;
    logic [1:0] eo;
    logic       fi;
  } fsp_row_type;
  localparam int DEB = 4;
  logic        clk_sys_i = 1'h0;
  logic        rst_i     = 1'h1;
  logic [15:0] addr_i    = 16'h0000;
  logic [7:0]  wdata_i   = 8'h00;
  logic        wr_i      = 1'h0;
  logic        rd_i      = 1'h0;
  logic        ce        = 1'h1;
  logic        lvl       = 1'h0;
  logic        lla       = 1'h0;
  logic        llb       = 1'h0;
  logic [7:0]  rdata;
  logic        pin, dout, a_clk, b_clk, c_clk, badc, fin, sref, irq;
  logic        pa, pb, pc, e;
  int          fail_count = 0;
  int          checks     = 0;
  // lv is {chan A flag, chan B flag, pin}; eo 2 = A clock, 3 = C clock
  fsp_row_type rows [10] = '{
    '{8'h08, 8'h00, 3'h4, 2'h1, 1'h0}, '{8'h18, 8'h00, 3'h4, 2'h0, 1'h0},
    '{8'h38, 8'h00, 3'h4, 2'h1, 1'h0}, '{8'h28, 8'h00, 3'h4, 2'h0, 1'h0},
    '{8'h30, 8'h00, 3'h6, 2'h3, 1'h0}, '{8'h70, 8'h08, 3'h6, 2'h2, 1'h0},
    '{8'h09, 8'h00, 3'h3, 2'h0, 1'h1}, '{8'h0D, 8'h00, 3'h0, 2'h0, 1'h1},
    '{8'h45, 8'h08, 3'h1, 2'h2, 1'h0}, '{8'h06, 8'h00, 3'h4, 2'h3, 1'h0}};

  always #4 clk_sys_i = ~clk_sys_i;
  // what the block saw at the last edge
  always @(posedge clk_sys_i) begin
    pa <= a_clk;
    pb <= b_clk;
    pc <= c_clk;
  end

  fsp_far_end peer (.clk_sys_i(clk_sys_i), .lvl_i(lvl), .pin_o(pin),
    .a_clk_o(a_clk), .b_clk_o(b_clk), .c_clk_o(c_clk));
  fsp_flag_sync_pin_config #(.DEBOUNCE_CYCLES(DEB)) dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
    .dual_in_pin_i(pin), .dual_out_pin_o(dout),
    .light_load_flag_chan_a_i(lla), .light_load_flag_chan_b_i(llb),
    .chan_a_clk_i(a_clk), .chan_c_clk_i(c_clk), .chan_b_clk_i(b_clk),
    .chan_b_adc_clk_o(badc), .flag_input_signal_o(fin),
    .sync_ref_o(sref), .irq_o(irq));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string nm);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'h1;
    @(posedge clk_sys_i);
    wr_i    <= 1'h0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] x,
                    input string nm);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'h1;
    @(posedge clk_sys_i);
    rd_i   <= 1'h0;
    @(negedge clk_sys_i);
    chk(rdata, x, nm);
  endtask : rd

  // delay d steps of SYNC_STEP_CYC from the sampled rising edge
  task automatic sync_try(input logic [7:0] d);
    wr(SYNC_DLY_ADDR, d);
    lvl <= 1'h0;
    repeat (3) @(posedge clk_sys_i);
    lvl <= 1'h1;
    @(posedge clk_sys_i);
    repeat (d * SYNC_STEP_CYC) begin
      @(negedge clk_sys_i);
      chk(sref, 8'h00, "sync ref early");
      @(posedge clk_sys_i);
    end
    @(negedge clk_sys_i);
    chk(sref, 8'h01, "sync ref pulse");
    @(negedge clk_sys_i);
    chk(sref, 8'h00, "sync ref end");
  endtask : sync_try

  task automatic end_sim;
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fail_count++;
    end_sim();
  end

  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    foreach (rows[i]) begin
      wr(PIN_FUNC_ADDR, rows[i].fn);
      wr(SYNC_SEL_ADDR, rows[i].sel);
      {lla, llb, lvl} <= rows[i].lv;
      repeat (3) @(posedge clk_sys_i);
      repeat (4) begin
        @(negedge clk_sys_i);
        e = rows[i].eo[1] ? (rows[i].eo[0] ? pc : pa) : rows[i].eo[0];
        chk(dout, e, "out pin");
        chk(fin, rows[i].fi, "flag in");
        chk(badc, pb ^ rows[i].fn[B_ILV_BIT], "b adc clk");
      end
    end
    // flag-in and flag-out rises seen above, no sync pulse yet
    rd(IRQ_STAT_ADDR, 8'h03, "status events");
    rd(IRQ_STAT_ADDR, 8'h00, "status cleared");
    sync_try(8'h00);
    sync_try(8'h01);
    sync_try(8'h03);
    chk(irq, 8'h00, "irq masked");
    wr(IRQ_MASK_ADDR, 8'h04);
    @(negedge clk_sys_i);
    chk(irq, 8'h01, "irq raised");
    rd(IRQ_STAT_ADDR, 8'h04, "status sync");
    chk(irq, 8'h00, "irq cleared");
    // glitch one edge short of the filter, then a real level
    wr(PIN_FUNC_ADDR, 8'h03);
    lvl <= 1'h0;
    repeat (8) @(posedge clk_sys_i);
    lvl <= 1'h1;
    repeat (DEB - 1) @(posedge clk_sys_i);
    lvl <= 1'h0;
    repeat (6) @(posedge clk_sys_i);
    lvl <= 1'h1;
    @(negedge clk_sys_i);
    chk(fin, 8'h00, "glitch");
    repeat (DEB - 1) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk(fin, 8'h00, "debounce early");
    @(negedge clk_sys_i);
    chk(fin, 8'h01, "debounce done");
    wr(16'hFE20, 8'h5A);
    rd(16'hFE20, 8'h00, "unmapped");
    wr(SYNC_SEL_ADDR, 8'hFF);
    rd(SYNC_SEL_ADDR, 8'hFF, "sel rw");
    rd(PIN_FUNC_ADDR, 8'h03, "func rw");
    rd(SYNC_DLY_ADDR, 8'h03, "dly rw");
    @(negedge clk_sys_i);
    chk(rdata, 8'h00, "rdata idle");
    // a write while the clock enable is low must be lost
    @(posedge clk_sys_i);
    ce <= 1'h0;
    wr(SYNC_SEL_ADDR, 8'h00);
    ce <= 1'h1;
    rd(SYNC_SEL_ADDR, 8'hFF, "ce freeze");
    @(posedge clk_sys_i);
    rst_i <= 1'h1;
    @(posedge clk_sys_i);
    rst_i <= 1'h0;
    @(negedge clk_sys_i);
    chk(dout, 8'h00, "out pin reset");
    chk(badc, 8'h00, "b adc reset");
    chk(fin, 8'h00, "flag in reset");
    chk(sref, 8'h00, "sync ref reset");
    chk(irq, 8'h00, "irq reset");
    rd(PIN_FUNC_ADDR, PIN_FUNC_RST, "func reset");
    rd(IRQ_MASK_ADDR, {5'h00, IRQ_MASK_RST}, "mask reset");
    end_sim();
  end
endmodule : fsp_flag_sync_pin_config_bench
